// ===== shared/lsf_cfg.svh
// line status word layout, reset value and counter widths
`ifndef LSF_CFG_SVH
`define LSF_CFG_SVH

`define LSF_BIT_FIFO_ERR 7
`define LSF_BIT_TX_EMPTY 6
`define LSF_BIT_THR_EMPTY 5
`define LSF_BIT_BREAK 4
`define LSF_BIT_FRAME_ERR 3
`define LSF_BIT_PARITY_ERR 2
`define LSF_BIT_OVERRUN 1
`define LSF_BIT_DATA_READY 0

`define LSF_STATUS_W 8
`define LSF_STATUS_RESET 8'h60
`define LSF_FRAME_CNT_W 4
`define LSF_FRAME_CNT_ZERO 4'h0
`define LSF_FRAME_CNT_ONE 4'h1

`endif

// ===== shared/lsf_pkg.sv
// types shared by the line status logic
`include "lsf_cfg.svh"

package lsf_pkg;

  typedef logic [`LSF_STATUS_W-1:0] lsf_status_t;
  typedef logic [`LSF_FRAME_CNT_W-1:0] lsf_cnt_t;

  typedef enum logic [1:0] {
    LSF_BRK_IDLE = 2'b00,
    LSF_BRK_COUNT = 2'b01,
    LSF_BRK_HELD = 2'b10
  } lsf_brk_e;

endpackage

// ===== logic/lsf_line_status.sv
// line status word of the uart: transmit empty flags and receive error flags
`include "lsf_cfg.svh"

module lsf_line_status (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic fifo_mode,
  input wire logic thr_irq_en,
  input wire logic status_rd,
  input wire logic tx_wr,
  input wire logic tx_load,
  input wire logic tx_shift_busy,
  input wire logic tx_fifo_empty,
  input wire logic rx_pin,
  input wire logic bit_tick,
  input wire lsf_pkg::lsf_cnt_t frame_bits,
  input wire logic rx_char_done,
  input wire logic rx_parity_bad,
  input wire logic rx_stop_bad,
  input wire logic rx_full,
  input wire logic rx_data_avail,
  input wire logic rx_err_in_fifo,
  input wire logic head_parity_bad,
  input wire logic head_stop_bad,
  input wire logic head_break,
  output lsf_pkg::lsf_status_t line_status,
  output logic tx_irq,
  output logic rx_store_en,
  output logic brk_push
);
  import lsf_pkg::*;

  // sticky flag: set wins over the read clear so no event is lost
  function automatic logic sticky(input logic cur, input logic set, input logic clr);
    sticky = set | (cur & ~clr);
  endfunction

  logic rx_meta_reg;
  logic rx_sync_reg;
  lsf_status_t line_status_reg;
  lsf_status_t line_status_next;
  lsf_brk_e brk_state_reg;
  lsf_brk_e brk_state_next;
  lsf_cnt_t brk_cnt_reg;
  lsf_cnt_t brk_cnt_next;
  logic brk_push_reg;
  logic brk_push_next;
  logic brk_event;
  logic thr_empty;

  // receive pin synchroniser
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rx_meta_reg <= 1'b1;
      rx_sync_reg <= 1'b1;
    end else begin
      rx_meta_reg <= rx_pin;
      rx_sync_reg <= rx_meta_reg;
    end
  end

  // break detector counts bit periods of a continuous low line
  always_comb begin
    brk_state_next = brk_state_reg;
    brk_cnt_next = brk_cnt_reg;
    brk_event = 1'b0;
    case (brk_state_reg)
      LSF_BRK_IDLE: begin
        brk_cnt_next = `LSF_FRAME_CNT_ZERO;
        if (!rx_sync_reg) begin
          brk_state_next = LSF_BRK_COUNT;
        end
      end
      LSF_BRK_COUNT: begin
        if (rx_sync_reg) begin
          brk_state_next = LSF_BRK_IDLE;
        end else if (bit_tick) begin
          brk_cnt_next = brk_cnt_reg + `LSF_FRAME_CNT_ONE;
          if (brk_cnt_reg + `LSF_FRAME_CNT_ONE >= frame_bits) begin
            brk_event = 1'b1;
            brk_state_next = LSF_BRK_HELD;
          end
        end
      end
      LSF_BRK_HELD: begin
        // stays here until the line returns high: one break per condition
        if (rx_sync_reg) begin
          brk_state_next = LSF_BRK_IDLE;
        end
      end
      default: begin
        brk_state_next = LSF_BRK_IDLE;
      end
    endcase
    brk_push_next = brk_event & fifo_mode;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      brk_state_reg <= LSF_BRK_IDLE;
      brk_cnt_reg <= `LSF_FRAME_CNT_ZERO;
      brk_push_reg <= 1'b0;
    end else begin
      brk_state_reg <= brk_state_next;
      brk_cnt_reg <= brk_cnt_next;
      brk_push_reg <= brk_push_next;
    end
  end

  // status word
  always_comb begin
    line_status_next = line_status_reg;
    // a write in the same cycle as a transfer leaves a character in the stage
    if (fifo_mode) begin
      thr_empty = tx_fifo_empty & ~tx_wr;
    end else begin
      thr_empty = ~tx_wr & (tx_load | line_status_reg[`LSF_BIT_THR_EMPTY]);
    end
    line_status_next[`LSF_BIT_THR_EMPTY] = thr_empty;
    if (fifo_mode) begin
      line_status_next[`LSF_BIT_TX_EMPTY] = tx_fifo_empty & ~tx_wr & ~tx_shift_busy;
    end else begin
      line_status_next[`LSF_BIT_TX_EMPTY] = thr_empty & ~tx_shift_busy;
    end
    line_status_next[`LSF_BIT_FIFO_ERR] =
      sticky(line_status_reg[`LSF_BIT_FIFO_ERR], fifo_mode & rx_err_in_fifo, status_rd);
    if (fifo_mode) begin
      // head flags come from the FIFO entry, so a read does not clear them
      line_status_next[`LSF_BIT_BREAK] = rx_data_avail & head_break;
      line_status_next[`LSF_BIT_FRAME_ERR] = rx_data_avail & head_stop_bad;
      line_status_next[`LSF_BIT_PARITY_ERR] = rx_data_avail & head_parity_bad;
    end else begin
      line_status_next[`LSF_BIT_BREAK] =
        sticky(line_status_reg[`LSF_BIT_BREAK], brk_event, status_rd);
      line_status_next[`LSF_BIT_FRAME_ERR] =
        sticky(line_status_reg[`LSF_BIT_FRAME_ERR], rx_char_done & rx_stop_bad, status_rd);
      line_status_next[`LSF_BIT_PARITY_ERR] =
        sticky(line_status_reg[`LSF_BIT_PARITY_ERR], rx_char_done & rx_parity_bad, status_rd);
    end
    line_status_next[`LSF_BIT_OVERRUN] =
      sticky(line_status_reg[`LSF_BIT_OVERRUN], rx_char_done & rx_full, status_rd);
    line_status_next[`LSF_BIT_DATA_READY] = rx_data_avail;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      line_status_reg <= `LSF_STATUS_RESET;
    end else begin
      line_status_reg <= line_status_next;
    end
  end

  assign line_status = line_status_reg;
  assign tx_irq = line_status_reg[`LSF_BIT_THR_EMPTY] & thr_irq_en;
  assign rx_store_en = rx_char_done & ~rx_full;
  assign brk_push = brk_push_reg;

endmodule

// ===== sim/lsf_line_status_asserts.sv
// assertions on the line status ports
module lsf_line_status_asserts (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic fifo_mode,
  input wire logic thr_irq_en,
  input wire logic status_rd,
  input wire logic tx_wr,
  input wire logic tx_fifo_empty,
  input wire logic rx_char_done,
  input wire logic rx_full,
  input wire logic rx_data_avail,
  input wire logic rx_err_in_fifo,
  input wire logic head_stop_bad,
  input wire logic tx_irq,
  input wire logic rx_store_en,
  input wire logic brk_push,
  input wire lsf_pkg::lsf_status_t line_status
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  ovr_set_a: assert property (rx_char_done && rx_full |=> line_status[1]) else $error("overrun");
  store_gate_a: assert property (rx_store_en == (rx_char_done && !rx_full)) else $error("store");
  irq_req_a: assert property (tx_irq == (line_status[5] && thr_irq_en)) else $error("irq");
  wr_clear_a: assert property (tx_wr |=> !line_status[5] && !line_status[6]) else $error("write");
  err_set_a: assert property (fifo_mode && rx_err_in_fifo |=> line_status[7]) else $error("fifo error");
  err_read_a: assert property (status_rd && !rx_err_in_fifo |=> !line_status[7]) else $error("read");
  fifo_hold_a: assert property (fifo_mode |=> line_status[5] == $past(tx_fifo_empty && !tx_wr))
    else $error("holding");
  one_push_a: assert property (brk_push |=> !brk_push) else $error("break push");
endmodule
bind lsf_line_status lsf_line_status_asserts u_lsf_line_status_asserts (.*);

// ===== sim/lsf_host_model.sv
// host side of the register bus: status reads and character writes
module lsf_host_model (
  input wire logic clk_sys,
  output logic status_rd,
  output logic tx_wr
);
  timeunit 1ns;
  timeprecision 100ps;
  initial {status_rd, tx_wr} = 2'b00;
  // one idle edge after each strobe so back-to-back calls never retoggle in one time step
  task automatic rd();
    status_rd = 1'b1;
    @(posedge clk_sys) #2 status_rd = 1'b0;
    @(posedge clk_sys) #2;
  endtask
  task automatic wr();
    tx_wr = 1'b1;
    @(posedge clk_sys) #2 tx_wr = 1'b0;
    @(posedge clk_sys) #2;
  endtask
endmodule

// ===== sim/lsf_line_status_tb.sv
// self-checking bench for the line status logic
module lsf_line_status_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import lsf_pkg::*;
  logic clk_sys = 0, rst = 1, fifo_mode = 0, thr_irq_en, tx_load = 0, tx_shift_busy = 0, tx_fifo_empty = 1;
  logic rx_pin = 1, bit_tick = 0, rx_char_done = 0, rx_parity_bad = 0, rx_stop_bad = 0, rx_full = 0;
  logic rx_data_avail = 0, rx_err_in_fifo = 0, head_parity_bad = 0, head_stop_bad = 0, head_break = 0;
  logic status_rd, tx_wr, tx_irq, rx_store_en, brk_push;
  lsf_cnt_t frame_bits = 4'h4;
  lsf_status_t line_status, notes[$];
  int num_errors = 0, tests_run = 0, pushes = 0;
  lsf_line_status u_lsf_line_status (.*);
  lsf_host_model u_lsf_host_model (.clk_sys, .status_rd, .tx_wr);
  always #12.5 clk_sys = ~clk_sys;
  task automatic check(string name, lsf_status_t seen, lsf_status_t exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic rd(lsf_status_t exp);
    notes.push_back(exp);
    u_lsf_host_model.rd();
  endtask
  task automatic step(int n);
    repeat (n) @(posedge clk_sys);
    #2;
  endtask
  // sampled mid-cycle, where the word read by the host has settled
  always @(negedge clk_sys) begin
    if (status_rd === 1'b1) check("line_status", line_status, notes.pop_front());
    if (brk_push === 1'b1) pushes++;
  end
  task automatic wrap_up();
    $display("%0d checks, %0d mismatches", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #1ms;
    num_errors++;
    wrap_up();
  end
  initial begin
    void'($urandom(32'h8049));
    thr_irq_en = 1'($urandom);
    step(6);
    rst = 0;
    step(1);
    rd(8'h60);
    u_lsf_host_model.wr();
    rd(8'h00);
    tx_load = 1;
    step(1);
    tx_load = 0;
    rd(8'h60);
    rd(8'h60);
    $display("transmit test done");
    for (int i = 0; i < 4; i++) begin
      {rx_stop_bad, rx_parity_bad} = i[0] ? 2'b00 : 2'($urandom);
      {rx_char_done, rx_full} = {1'b1, i[0]};
      step(1);
      rx_char_done = 0;
      rd({4'h6, rx_stop_bad, rx_parity_bad, i[0], 1'b0});
      rd(8'h60);
    end
    $display("receive error test done");
    {fifo_mode, rx_full, rx_err_in_fifo, rx_data_avail, head_stop_bad, head_parity_bad} = 6'h2f;
    step(1);
    rx_err_in_fifo = 0;
    rd(8'hed);
    rd(8'h6d);
    {rx_data_avail, head_stop_bad, head_parity_bad, tx_fifo_empty} = 4'h0;
    step(1);
    rd(8'h00);
    tx_fifo_empty = 1;
    $display("fifo test done");
    {rx_pin, bit_tick} = 2'b01;
    step(40);
    rx_pin = 1;
    step(4);
    check("brk_push", 8'(pushes), 8'h01);
    {fifo_mode, rx_pin} = 2'b00;
    step(20);
    rx_pin = 1;
    step(4);
    rd(8'h70);
    check("tx_irq", 8'(tx_irq), 8'(thr_irq_en));
    $display("break test done");
    wrap_up();
  end
endmodule
